// ==== logic/dtc_timer_core.sv ====
// dual timer/counter with external interrupt flags behind the register port
//
// Function
// - two 16-bit counters, each low and high byte
// - timer one overflow sets bit 7, ack clears
// - timer zero overflow sets bit 5, ack clears
// - bit 6 runs or halts timer one
// - bit 4 runs or halts timer zero
// - pin one event sets interrupt flag bit 3
// - pin zero event sets interrupt flag bit 1
// - bits 2 and 0 choose edge or level
// - gated timer one runs only while pin high
// - gated timer zero runs only while pin high
// - mode bit 6 picks timer one source
// - mode bit 2 picks timer zero source
// - timer one mode in bits 5 and 4
// - timer zero mode in bits 1 and 0
// - modes 13-bit, 16-bit, 8-bit auto-reload
// - split mode: high byte under timer one run bit
// - timer one in split mode holds and stops
// - reload mode copies high byte on overflow
// - all four count bytes reset to zero
// - internal count clock is 5 MHz
`timescale 1ns/1ps
module dtc_timer_core (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr_en,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd_en,
  output logic      [7:0] sfr_rdata,
  input  wire logic       ext_irq_pin_zero,
  input  wire logic       ext_irq_pin_one,
  input  wire logic       ext_count_pin_zero,
  input  wire logic       ext_count_pin_one,
  input  wire logic       isr_ack_timer_zero,
  input  wire logic       isr_ack_timer_one,
  input  wire logic       isr_ack_irq_zero,
  input  wire logic       isr_ack_irq_one,
  output logic            timer_zero_overflow_flag,
  output logic            timer_one_overflow_flag,
  output logic            ext_irq_zero_flag,
  output logic            ext_irq_one_flag
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] timer_zero_low_byte;
  logic [7:0] timer_zero_high_byte;
  logic [7:0] timer_one_low_byte;
  logic [7:0] timer_one_high_byte;
  logic [7:0] timer_mode_select;
  logic       timer_zero_run;
  logic       timer_one_run;
  logic       ext_irq_zero_edge_select;
  logic       ext_irq_one_edge_select;
  logic [4:0] tick_count;
  logic       tick;
  logic [1:0] zero_mode;
  logic [1:0] one_mode;
  logic       timer_zero_pin_gating;
  logic       timer_one_pin_gating;
  logic       timer_zero_source_select;
  logic       timer_one_source_select;
  logic       zero_inc;
  logic       one_inc;
  logic       split_inc;
  logic       zero_ovf_evt;
  logic       one_ovf_evt;
  logic       split_ovf_evt;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_zero_low;
  logic       wr_zero_high;
  logic       wr_one_low;
  logic       wr_one_high;
  logic       wr_count;
  dtc_step_s  zero_step;
  dtc_step_s  one_step;
  logic [7:0] ctrl_view;

  dtc_pin_if irq_zero_if ();
  dtc_pin_if irq_one_if ();
  dtc_pin_if cnt_zero_if ();
  dtc_pin_if cnt_one_if ();

  // ----------------------------------------------------------------
  // one count step of a timer in the given mode
  // ----------------------------------------------------------------
  function automatic dtc_step_s dtc_step(input logic [1:0] mode,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
    dtc_step_s   r;
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    r     = '{ovf: 1'b0, hi: hi, lo: lo};
    c13   = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16   = {1'b0, hi, lo} + 17'h00001;
    c8    = {1'b0, lo} + 9'h001;
    unique case (mode)
      MODE_13BIT: begin
        // upper three low-byte bits are left untouched
        r.hi  = c13[12:5];
        r.lo  = {lo[7:5], c13[4:0]};
        r.ovf = c13[13];
      end
      MODE_16BIT: begin
        r.hi  = c16[15:8];
        r.lo  = c16[7:0];
        r.ovf = c16[16];
      end
      MODE_RELOAD: begin
        r.lo  = c8[8] ? hi : c8[7:0];
        r.ovf = c8[8];
      end
      MODE_SPLIT: begin
        // only the low byte steps here; the high byte is handled apart
        r.lo  = c8[7:0];
        r.ovf = c8[8];
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign irq_zero_if.raw = ext_irq_pin_zero;
  assign irq_one_if.raw  = ext_irq_pin_one;
  assign cnt_zero_if.raw = ext_count_pin_zero;
  assign cnt_one_if.raw  = ext_count_pin_one;

  dtc_pin_sync u_sync_irq_zero (.sys_clk(sys_clk), .rst_b(rst_b), .pin(irq_zero_if));
  dtc_pin_sync u_sync_irq_one  (.sys_clk(sys_clk), .rst_b(rst_b), .pin(irq_one_if));
  dtc_pin_sync u_sync_cnt_zero (.sys_clk(sys_clk), .rst_b(rst_b), .pin(cnt_zero_if));
  dtc_pin_sync u_sync_cnt_one  (.sys_clk(sys_clk), .rst_b(rst_b), .pin(cnt_one_if));

  // ----------------------------------------------------------------
  // 5 MHz timer tick from the system clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_count <= 5'h00;
    end else if (tick_count == TICK_LAST) begin
      tick_count <= 5'h00;
    end else begin
      tick_count <= tick_count + 5'h01;
    end
  end
  assign tick = (tick_count == TICK_LAST);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_ctrl      = sfr_wr_en && (sfr_addr == ADDR_RUN_IRQ_CTRL);
  assign wr_mode      = sfr_wr_en && (sfr_addr == ADDR_MODE_SELECT);
  assign wr_zero_low  = sfr_wr_en && (sfr_addr == ADDR_ZERO_LOW);
  assign wr_zero_high = sfr_wr_en && (sfr_addr == ADDR_ZERO_HIGH);
  assign wr_one_low   = sfr_wr_en && (sfr_addr == ADDR_ONE_LOW);
  assign wr_one_high  = sfr_wr_en && (sfr_addr == ADDR_ONE_HIGH);
  assign wr_count     = wr_zero_low || wr_zero_high || wr_one_low || wr_one_high;

  // mode register fields
  assign timer_one_pin_gating     = timer_mode_select[BIT_ONE_GATE];
  assign timer_one_source_select  = timer_mode_select[BIT_ONE_SRC];
  assign one_mode = {timer_mode_select[BIT_ONE_MODE_U],
                     timer_mode_select[BIT_ONE_MODE_L]};
  assign timer_zero_pin_gating    = timer_mode_select[BIT_ZERO_GATE];
  assign timer_zero_source_select = timer_mode_select[BIT_ZERO_SRC];
  assign zero_mode = {timer_mode_select[BIT_ZERO_MODE_U],
                      timer_mode_select[BIT_ZERO_MODE_L]};

  // ----------------------------------------------------------------
  // count enables: run bit, optional pin gate, then source
  // ----------------------------------------------------------------
  assign zero_inc = timer_zero_run
                 && (!timer_zero_pin_gating || irq_zero_if.level)
                 && (timer_zero_source_select ? cnt_zero_if.fall : tick);
  // split high byte counts timer ticks under the timer one run bit
  assign split_inc = (zero_mode == MODE_SPLIT) && timer_one_run && tick;
  assign one_inc = timer_one_run
                && (one_mode != MODE_SPLIT)
                && (!timer_one_pin_gating || irq_one_if.level)
                && (timer_one_source_select ? cnt_one_if.fall : tick);

  assign zero_step     = dtc_step(zero_mode, timer_zero_low_byte, timer_zero_high_byte);
  assign one_step      = dtc_step(one_mode, timer_one_low_byte, timer_one_high_byte);
  assign zero_ovf_evt  = zero_inc && zero_step.ovf;
  assign split_ovf_evt = split_inc && (timer_zero_high_byte == 8'hFF);
  // in split mode the timer one flag belongs to the zero high byte
  assign one_ovf_evt   = (one_inc && one_step.ovf && (zero_mode != MODE_SPLIT))
                      || split_ovf_evt;

  // ----------------------------------------------------------------
  // timer zero count bytes; a software write beats a count step
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_zero_low_byte <= RST_COUNT_BYTE;
    end else if (wr_zero_low) begin
      timer_zero_low_byte <= sfr_wdata;
    end else if (zero_inc) begin
      timer_zero_low_byte <= zero_step.lo;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_zero_high_byte <= RST_COUNT_BYTE;
    end else if (wr_zero_high) begin
      timer_zero_high_byte <= sfr_wdata;
    end else if (split_inc) begin
      timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
    end else if (zero_inc && (zero_mode != MODE_SPLIT)) begin
      timer_zero_high_byte <= zero_step.hi;
    end
  end

  // ----------------------------------------------------------------
  // timer one count bytes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_one_low_byte  <= RST_COUNT_BYTE;
      timer_one_high_byte <= RST_COUNT_BYTE;
    end else begin
      if (wr_one_low) begin
        timer_one_low_byte <= sfr_wdata;
      end else if (one_inc) begin
        timer_one_low_byte <= one_step.lo;
      end
      if (wr_one_high) begin
        timer_one_high_byte <= sfr_wdata;
      end else if (one_inc) begin
        timer_one_high_byte <= one_step.hi;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode register and control bits written only by software
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_mode_select        <= RST_MODE_SELECT;
      timer_one_run            <= RST_RUN_IRQ_CTRL[BIT_ONE_RUN];
      timer_zero_run           <= RST_RUN_IRQ_CTRL[BIT_ZERO_RUN];
      ext_irq_one_edge_select  <= RST_RUN_IRQ_CTRL[BIT_IRQ1_EDGE];
      ext_irq_zero_edge_select <= RST_RUN_IRQ_CTRL[BIT_IRQ0_EDGE];
    end else begin
      if (wr_mode) begin
        timer_mode_select <= sfr_wdata;
      end
      if (wr_ctrl) begin
        timer_one_run            <= sfr_wdata[BIT_ONE_RUN];
        timer_zero_run           <= sfr_wdata[BIT_ZERO_RUN];
        ext_irq_one_edge_select  <= sfr_wdata[BIT_IRQ1_EDGE];
        ext_irq_zero_edge_select <= sfr_wdata[BIT_IRQ0_EDGE];
      end
    end
  end

  // ----------------------------------------------------------------
  // overflow flags: a hardware set wins over ack and over a write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_one_overflow_flag  <= RST_RUN_IRQ_CTRL[BIT_ONE_OVF];
      timer_zero_overflow_flag <= RST_RUN_IRQ_CTRL[BIT_ZERO_OVF];
    end else begin
      if (one_ovf_evt) begin
        timer_one_overflow_flag <= 1'b1;
      end else if (isr_ack_timer_one) begin
        timer_one_overflow_flag <= 1'b0;
      end else if (wr_ctrl) begin
        timer_one_overflow_flag <= sfr_wdata[BIT_ONE_OVF];
      end
      if (zero_ovf_evt) begin
        timer_zero_overflow_flag <= 1'b1;
      end else if (isr_ack_timer_zero) begin
        timer_zero_overflow_flag <= 1'b0;
      end else if (wr_ctrl) begin
        timer_zero_overflow_flag <= sfr_wdata[BIT_ZERO_OVF];
      end
    end
  end

  // ----------------------------------------------------------------
  // external interrupt flags; level mode ignores ack and writes,
  // since the flag is just the inverted pin and would come straight back
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq_one_flag  <= RST_RUN_IRQ_CTRL[BIT_IRQ1_FLAG];
      ext_irq_zero_flag <= RST_RUN_IRQ_CTRL[BIT_IRQ0_FLAG];
    end else begin
      if (!ext_irq_one_edge_select) begin
        ext_irq_one_flag <= !irq_one_if.level;
      end else if (irq_one_if.fall) begin
        ext_irq_one_flag <= 1'b1;
      end else if (isr_ack_irq_one) begin
        ext_irq_one_flag <= 1'b0;
      end else if (wr_ctrl) begin
        ext_irq_one_flag <= sfr_wdata[BIT_IRQ1_FLAG];
      end
      if (!ext_irq_zero_edge_select) begin
        ext_irq_zero_flag <= !irq_zero_if.level;
      end else if (irq_zero_if.fall) begin
        ext_irq_zero_flag <= 1'b1;
      end else if (isr_ack_irq_zero) begin
        ext_irq_zero_flag <= 1'b0;
      end else if (wr_ctrl) begin
        ext_irq_zero_flag <= sfr_wdata[BIT_IRQ0_FLAG];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, registered one cycle after the read strobe
  // ----------------------------------------------------------------
  assign ctrl_view = {timer_one_overflow_flag, timer_one_run,
                      timer_zero_overflow_flag, timer_zero_run,
                      ext_irq_one_flag, ext_irq_one_edge_select,
                      ext_irq_zero_flag, ext_irq_zero_edge_select};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd_en) begin
      unique case (sfr_addr)
        ADDR_RUN_IRQ_CTRL: sfr_rdata <= ctrl_view;
        ADDR_MODE_SELECT:  sfr_rdata <= timer_mode_select;
        ADDR_ZERO_LOW:     sfr_rdata <= timer_zero_low_byte;
        ADDR_ONE_LOW:      sfr_rdata <= timer_one_low_byte;
        ADDR_ZERO_HIGH:    sfr_rdata <= timer_zero_high_byte;
        ADDR_ONE_HIGH:     sfr_rdata <= timer_one_high_byte;
        default:           sfr_rdata <= 8'h00; // other addresses read as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  tick_period_a: assert property (tick |-> ##20 tick)
    else $error("timer tick period is not twenty cycles");

  one_ovf_set_a: assert property (one_ovf_evt |=> timer_one_overflow_flag)
    else $error("timer one overflow flag not set");

  zero_ack_clear_a: assert property (
    isr_ack_timer_zero && !zero_ovf_evt |=> !timer_zero_overflow_flag)
    else $error("timer zero overflow flag not cleared by ack");

  zero_halt_a: assert property (
    !timer_zero_run && !wr_zero_low |=> $stable(timer_zero_low_byte))
    else $error("timer zero low byte moved while halted");

  one_halt_a: assert property (
    !timer_one_run && !wr_count
    |=> $stable({timer_one_high_byte, timer_one_low_byte}))
    else $error("timer one moved while halted");

  one_split_hold_a: assert property (
    one_mode == MODE_SPLIT && !wr_count
    |=> $stable({timer_one_high_byte, timer_one_low_byte}))
    else $error("timer one moved in split mode");

  zero_gate_a: assert property (
    timer_zero_pin_gating && !irq_zero_if.level && !wr_zero_low
    |=> $stable(timer_zero_low_byte))
    else $error("gated timer zero counted with pin low");

  reload_copy_a: assert property (
    zero_mode == MODE_RELOAD && zero_inc && timer_zero_low_byte == 8'hFF && !wr_count
    |=> timer_zero_low_byte == $past(timer_zero_high_byte) && timer_zero_overflow_flag)
    else $error("auto-reload did not copy high byte");

  irq_level_a: assert property (
    !ext_irq_zero_edge_select |=> ext_irq_zero_flag == !$past(irq_zero_if.level))
    else $error("level interrupt flag does not follow pin");

  irq_edge_a: assert property (
    ext_irq_one_edge_select && irq_one_if.fall |=> ext_irq_one_flag)
    else $error("edge interrupt flag not latched");

endmodule : dtc_timer_core

// ==== logic/dtc_pkg.sv ====
// constants, field positions and types shared by the dual timer/counter block
package dtc_pkg;

  // ----------------------------------------------------------------
  // register offsets on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_IRQ_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE_SELECT  = 8'h89;
  localparam logic [7:0] ADDR_ZERO_LOW     = 8'h8A;
  localparam logic [7:0] ADDR_ONE_LOW      = 8'h8B;
  localparam logic [7:0] ADDR_ZERO_HIGH    = 8'h8C;
  localparam logic [7:0] ADDR_ONE_HIGH     = 8'h8D;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RUN_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE_SELECT  = 8'h00;
  localparam logic [7:0] RST_COUNT_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // bit positions in the run / interrupt control register
  // ----------------------------------------------------------------
  localparam int BIT_ONE_OVF   = 7;
  localparam int BIT_ONE_RUN   = 6;
  localparam int BIT_ZERO_OVF  = 5;
  localparam int BIT_ZERO_RUN  = 4;
  localparam int BIT_IRQ1_FLAG = 3;
  localparam int BIT_IRQ1_EDGE = 2;
  localparam int BIT_IRQ0_FLAG = 1;
  localparam int BIT_IRQ0_EDGE = 0;

  // ----------------------------------------------------------------
  // bit positions in the mode select register
  // ----------------------------------------------------------------
  localparam int BIT_ONE_GATE   = 7;
  localparam int BIT_ONE_SRC    = 6;
  localparam int BIT_ONE_MODE_U = 5;
  localparam int BIT_ONE_MODE_L = 4;
  localparam int BIT_ZERO_GATE  = 3;
  localparam int BIT_ZERO_SRC   = 2;
  localparam int BIT_ZERO_MODE_U = 1;
  localparam int BIT_ZERO_MODE_L = 0;

  // ----------------------------------------------------------------
  // operating modes of the two-bit mode field
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // ----------------------------------------------------------------
  // timing: internal timer clock derived from the system clock
  // ----------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int TIMER_CLK_HZ      = 5_000_000;
  localparam int TIMER_PERIOD_NS   = 1_000_000_000 / TIMER_CLK_HZ;
  localparam int TICK_CYCLES       = TIMER_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

  // result of one count step
  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_step_s;

endpackage : dtc_pkg

// ==== logic/dtc_pin_if.sv ====
// carrier between a pin synchroniser and the timer logic
`timescale 1ns/1ps
interface dtc_pin_if;
  logic raw;
  logic level;
  logic fall;

  modport filt (input raw, output level, output fall);
  modport user (output raw, input level, input fall);
endinterface : dtc_pin_if

// ==== logic/dtc_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ps
module dtc_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  dtc_pin_if.filt  pin
);
  import dtc_pkg::*;

  logic stage1;
  logic stage2;
  logic stage3;
  logic stable;
  logic fall_q;

  // ----------------------------------------------------------------
  // synchroniser chain; pins idle high so reset to one avoids a false edge
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= pin.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a new level only once the last two stages agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stable <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      fall_q <= (stage2 == stage3) && stable && !stage3;
      if (stage2 == stage3) begin
        stable <= stage3;
      end
    end
  end

  assign pin.level = stable;
  assign pin.fall  = fall_q;

  // a falling pulse lasts one cycle and leaves the level low
  fall_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pin.fall |-> !pin.level ##1 !pin.fall)
    else $error("falling pulse not one cycle wide");

endmodule : dtc_pin_sync

// ==== tb/dtc_core_model.sv ====
// processor-side model that reaches the timer block through its register port
`timescale 1ns/1ps
module dtc_core_model (
  input  wire logic       sys_clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr_en,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd_en,
  input  wire logic [7:0] sfr_rdata
);
  // ------------------------------------------------------------
  // idle bus; strobes low so nothing is taken during reset
  // ------------------------------------------------------------
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr_en = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd_en = 1'b0;
  end

  // one-cycle write strobe, address and data held over the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge sys_clk);
    sfr_wr_en <= 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_rd_en <= 1'b1;
    @(posedge sys_clk);
    sfr_rd_en <= 1'b0;
    @(posedge sys_clk);
    q = sfr_rdata;
  endtask
endmodule // dtc_core_model

// ==== tb/dual_timer_counter_ext_irq_bench.sv ====
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_bench;
  logic       sys_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic [7:0] addr, wdata, rdata, q;
  logic       wr_en, rd_en;
  logic [1:0] irq_pin = 2'h3, cnt_pin = 2'h3, ack_ov = 2'h0, ack_irq = 2'h0;
  logic [3:0] flags;
  int         error_cnt = 0, cmp_count = 0, cyc = 0;

  dtc_core_model u_core (.sys_clk(sys_clk), .sfr_addr(addr), .sfr_wr_en(wr_en),
    .sfr_wdata(wdata), .sfr_rd_en(rd_en), .sfr_rdata(rdata));
  dtc_timer_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(addr),
    .sfr_wr_en(wr_en), .sfr_wdata(wdata), .sfr_rd_en(rd_en), .sfr_rdata(rdata),
    .ext_irq_pin_zero(irq_pin[0]), .ext_irq_pin_one(irq_pin[1]),
    .ext_count_pin_zero(cnt_pin[0]), .ext_count_pin_one(cnt_pin[1]),
    .isr_ack_timer_zero(ack_ov[0]), .isr_ack_timer_one(ack_ov[1]),
    .isr_ack_irq_zero(ack_irq[0]), .isr_ack_irq_one(ack_irq[1]),
    .timer_zero_overflow_flag(flags[0]), .timer_one_overflow_flag(flags[1]),
    .ext_irq_zero_flag(flags[2]), .ext_irq_one_flag(flags[3]));

  // ------------------------------------------------------------
  // clock, and a cycle ceiling well above the roughly 400-cycle run
  // ------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_core.rd(a, q);
    chk(q, e);
  endtask

  // bounded wait on one flag; a flag that never rises shows as a mismatch
  task automatic wflag(input int i, input logic v);
    for (int k = 0; k < 60 && flags[i] !== v; k++) @(posedge sys_clk);
    chk({7'h00, flags[i]}, {7'h00, v});
  endtask

  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 8'h88; a <= 8'h8D; a++) rchk(8'(a), 8'h00);
    u_core.wr(8'h90, 8'h5A);
    rchk(8'h90, 8'h00);
    u_core.wr(8'h89, 8'hA5);
    rchk(8'h89, 8'hA5);
    // 16-bit timer zero rolls over; ack clears its flag
    u_core.wr(8'h89, 8'h01);
    u_core.wr(8'h8A, 8'hFF);
    u_core.wr(8'h8C, 8'hFF);
    u_core.wr(8'h88, 8'h10);
    wflag(0, 1'b1);
    rchk(8'h8C, 8'h00);
    ack_ov[0] <= 1'b1;
    @(posedge sys_clk);
    ack_ov[0] <= 1'b0;
    wflag(0, 1'b0);
    // both timers auto-reload on the same tick, then halted by their run bits
    u_core.wr(8'h88, 8'h00);
    u_core.wr(8'h89, 8'h22);
    u_core.wr(8'h8D, 8'hF0);
    u_core.wr(8'h8B, 8'hFF);
    u_core.wr(8'h8C, 8'hF0);
    u_core.wr(8'h8A, 8'hFF);
    u_core.wr(8'h88, 8'h50);
    wflag(1, 1'b1);
    wflag(0, 1'b1);
    u_core.wr(8'h88, 8'h00);
    repeat (60) @(posedge sys_clk);
    rchk(8'h8B, 8'hF0);
    rchk(8'h8A, 8'hF0);
    // 13-bit mode: five low bits below the high byte
    u_core.wr(8'h89, 8'h00);
    u_core.wr(8'h8A, 8'h1F);
    u_core.wr(8'h8C, 8'hFF);
    u_core.wr(8'h88, 8'h10);
    wflag(0, 1'b1);
    u_core.wr(8'h88, 8'h00);
    rchk(8'h8C, 8'h00);
    // gated timers with their pins low: no count, level flag follows pin;
    // pins drop first so the synchronised level is low before the run bits
    irq_pin <= 2'h0;
    u_core.wr(8'h89, 8'h99);
    u_core.wr(8'h8A, 8'h00);
    u_core.wr(8'h8B, 8'h00);
    u_core.wr(8'h88, 8'h50);
    repeat (60) @(posedge sys_clk);
    rchk(8'h8A, 8'h00);
    rchk(8'h8B, 8'h00);
    chk({7'h00, flags[2]}, 8'h01);
    u_core.wr(8'h88, 8'h00);
    irq_pin <= 2'h3;
    wflag(2, 1'b0);
    // edge-triggered interrupt on each pin, then serviced
    for (int i = 0; i < 2; i++) begin
      u_core.wr(8'h88, i ? 8'h04 : 8'h01);
      irq_pin[i] <= 1'b0;
      repeat (10) @(posedge sys_clk);
      irq_pin[i] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rchk(8'h88, i ? 8'h0C : 8'h03);
      ack_irq[i] <= 1'b1;
      @(posedge sys_clk);
      ack_irq[i] <= 1'b0;
      wflag(2 + i, 1'b0);
    end
    // both timers counting falls of their count pins
    u_core.wr(8'h89, 8'h55);
    u_core.wr(8'h8A, 8'h00);
    u_core.wr(8'h8B, 8'h00);
    u_core.wr(8'h88, 8'h50);
    repeat (3) begin
      cnt_pin <= 2'h0;
      repeat (8) @(posedge sys_clk);
      cnt_pin <= 2'h3;
      repeat (8) @(posedge sys_clk);
    end
    u_core.wr(8'h88, 8'h00);
    rchk(8'h8A, 8'h03);
    rchk(8'h8B, 8'h03);
    // split mode: high byte of timer zero runs under the timer one run bit
    u_core.wr(8'h89, 8'h33);
    u_core.wr(8'h8C, 8'hFF);
    u_core.wr(8'h8B, 8'h55);
    u_core.wr(8'h88, 8'h40);
    wflag(1, 1'b1);
    u_core.wr(8'h88, 8'h00);
    rchk(8'h8C, 8'h00);
    rchk(8'h8A, 8'h03);
    rchk(8'h8B, 8'h55);
    final_report();
  end
endmodule // dual_timer_counter_ext_irq_bench
